// >>> hdl/ana_params.svh
`ifndef ANA_PARAMS_SVH
`define ANA_PARAMS_SVH

// ************************************************************
// Register indices; byte address is four times the index.
// ************************************************************
`define ANA_IDX_CTRL    6'h00
`define ANA_IDX_ADV     6'h04
`define ANA_IDX_LP      6'h05
`define ANA_IDX_GIG     6'h09
`define ANA_IDX_PSC     6'h10
`define ANA_IDX_STAT    6'h11

// ************************************************************
// Control register bit positions, and the PSC power-down bit.
// ************************************************************
`define ANA_CTRL_SWRST  15
`define ANA_CTRL_SPDLSB 13
`define ANA_CTRL_ANEN   12
`define ANA_CTRL_PDN    11
`define ANA_CTRL_RESTRT 9
`define ANA_CTRL_DUPLEX 8
`define ANA_CTRL_SPDMSB 6
`define ANA_PSC_PDN     2

// ************************************************************
// Field positions and reset values.
// ************************************************************
`define ANA_ADV_10M_HI  6
`define ANA_ADV_10M_LO  5
`define ANA_SEL_HI      4
`define ANA_GIG_FD      9
`define ANA_GIG_HD      8
`define ANA_CTRL_RST    16'h1100
`define ANA_ADV10_RST   2'h3
`define ANA_SEL_RST     5'h01
`define ANA_GIG_RST     2'h3
`define ANA_LP_RST      16'h0000

`endif

// >>> hdl/ana_pkg.sv
package ana_pkg;

    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        ANA_IDLE = 2'b01,
        ANA_ACK  = 2'b10
    } ana_state_e;

    // Partner page capture state.
    typedef struct packed {
        logic [15:0] page;
    } ana_cap_s;

    // State of the register bank, apart from the partner page.
    typedef struct packed {
        ana_state_e  st;
        logic        ack;
        logic [31:0] dat;
        logic [15:0] ctrl;
        logic        pdn2;
        logic [1:0]  gig;
        logic [1:0]  pend;
        logic [1:0]  app;
        logic [4:0]  sel;
        logic        lnk_s1;
        logic        lnk_s2;
        logic        lnk_d;
        logic [15:0] adv;
        logic        fd;
        logic        hd;
        logic        run;
        logic        rstrt;
        logic        swrst;
    } ana_regs_s;

endpackage

// >>> hdl/ana_page_capture.sv
`timescale 1ns/1ps
`include "ana_params.svh"

module ana_page_capture (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clr,
    input  wire logic [15:0] rx_page_i,
    input  wire logic        rx_page_valid_i,
    output logic      [15:0] page_o
);

    ana_pkg::ana_cap_s s_r;
    ana_pkg::ana_cap_s s_nxt;

    // A whole code word is taken in one edge, so a read never sees a mix.
    // A load in the same cycle as a clear wins, so no page is lost.
    always_comb begin
        s_nxt = s_r;
        if (rx_page_valid_i) begin
            s_nxt.page = rx_page_i;
        end else if (clr) begin
            s_nxt.page = `ANA_LP_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.page <= `ANA_LP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign page_o = s_r.page;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_np;
        rx_page_valid_i |=> page_o[15] == $past(rx_page_i[15]);
    endproperty
    a_np: assert property (p_np)
        else $error("next page bit not mirrored");

    property p_ackb;
        rx_page_valid_i |=> page_o[14] == $past(rx_page_i[14]);
    endproperty
    a_ackb: assert property (p_ackb)
        else $error("acknowledge bit not mirrored");

    property p_rf;
        rx_page_valid_i |=> page_o[13] == $past(rx_page_i[13]);
    endproperty
    a_rf: assert property (p_rf)
        else $error("remote fault bit not mirrored");

    property p_pause;
        rx_page_valid_i |=> page_o[11:10] == $past(rx_page_i[11:10]);
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause bits not mirrored");

    property p_tech;
        rx_page_valid_i |=> page_o[9:5] == $past(rx_page_i[9:5]);
    endproperty
    a_tech: assert property (p_tech)
        else $error("ability bits not mirrored");

    property p_clr;
        clr && !rx_page_valid_i |=> page_o == 16'h0000;
    endproperty
    a_clr: assert property (p_clr)
        else $error("partner word not cleared");

    property p_selr;
        rx_page_valid_i |=> page_o[4:0] == $past(rx_page_i[4:0]);
    endproperty
    a_selr: assert property (p_selr)
        else $error("partner selector not mirrored");

    property p_hold;
        !rx_page_valid_i && !clr |=> $stable(page_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("partner word changed without a page");

endmodule

// >>> hdl/ana_regs.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "ana_params.svh"


module ana_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        link_up_pin,
    input  wire logic [15:0] rx_page_i,
    input  wire logic        rx_page_valid_i,
    output logic      [15:0] adv_word_o,
    output logic             adv_1000_fd_o,
    output logic             adv_1000_hd_o,
    output logic             an_run_o,
    output logic             an_restart_o
);

    ana_pkg::ana_regs_s s_r;
    ana_pkg::ana_regs_s s_nxt;
    logic [15:0]        lp_page;
    logic [5:0]         idx;
    logic               req;
    logic               wr;
    logic [15:0]        wv;
    logic               upd;
    logic               forced;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Byte-lane merge for the 16-bit registers in the low word.
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // Forced 1000: AN bit off, speed select reads one-zero.
    function automatic logic is_forced(input logic [15:0] c);
        return !c[`ANA_CTRL_ANEN] && c[`ANA_CTRL_SPDMSB] &&
               !c[`ANA_CTRL_SPDLSB];
    endfunction

    // ************************************************************
    // Partner page
    // ************************************************************

    // The received word is only ever written by the capture module.
    ana_page_capture u_cap (
        .clk             (clk),
        .rst             (rst),
        .clr             (s_r.swrst),
        .rx_page_i       (rx_page_i),
        .rx_page_valid_i (rx_page_valid_i),
        .page_o          (lp_page)
    );

    // ************************************************************
    // Next state
    // ************************************************************

    // Bus decode; writes land at the edge where the master sees ack.
    assign idx    = wb_adr_i[7:2];
    assign req    = wb_cyc_i && wb_stb_i;
    assign wr     = req && wb_we_i && (s_r.st == ana_pkg::ANA_ACK);
    assign forced = is_forced(s_r.ctrl);

    always_comb begin
        s_nxt       = s_r;
        s_nxt.swrst = 1'b0;
        s_nxt.rstrt = 1'b0;
        wv          = 16'h0000;
        upd         = 1'b0;
        // Two-stage synchroniser, then a delayed copy for the edge.
        s_nxt.lnk_s1 = link_up_pin;
        s_nxt.lnk_s2 = s_r.lnk_s1;
        s_nxt.lnk_d  = s_r.lnk_s2;
        if (s_r.lnk_d && !s_r.lnk_s2) begin
            upd = 1'b1;
        end
        // Bus slave: answer one cycle after the request, drop next cycle.
        case (s_r.st)
            ana_pkg::ANA_IDLE: begin
                s_nxt.ack = 1'b0;
                if (req) begin
                    s_nxt.st  = ana_pkg::ANA_ACK;
                    s_nxt.ack = 1'b1;
                    s_nxt.dat = 32'h0000_0000;
                    case (idx)
                        `ANA_IDX_CTRL: s_nxt.dat[15:0] = s_r.ctrl;
                        `ANA_IDX_ADV: begin
                            s_nxt.dat[6:5] = s_r.pend;
                            s_nxt.dat[4:0] = s_r.sel;
                        end
                        `ANA_IDX_LP:   s_nxt.dat[15:0] = lp_page;
                        `ANA_IDX_GIG:  s_nxt.dat[9:8] = s_r.gig;
                        `ANA_IDX_PSC:  s_nxt.dat[2] = s_r.pdn2;
                        `ANA_IDX_STAT: begin
                            s_nxt.dat[0]   = s_r.lnk_s2;
                            s_nxt.dat[1]   = s_r.run;
                            s_nxt.dat[3:2] = s_r.app;
                        end
                        default: s_nxt.dat = 32'h0000_0000;
                    endcase
                end
            end
            ana_pkg::ANA_ACK: begin
                s_nxt.st  = ana_pkg::ANA_IDLE;
                s_nxt.ack = 1'b0;
            end
            default: begin
                s_nxt.st  = ana_pkg::ANA_IDLE;
                s_nxt.ack = 1'b0;
            end
        endcase
        // Register writes; unmapped indices, the partner word and the status word ignore them.
        if (wr) begin
            case (idx)
                `ANA_IDX_CTRL: begin
                    wv = merge(s_r.ctrl, wb_dat_i, wb_sel_i);
                    if (wv[`ANA_CTRL_SWRST] || wv[`ANA_CTRL_RESTRT]) begin
                        upd = 1'b1;
                    end
                    if (s_r.ctrl[`ANA_CTRL_PDN] && !wv[`ANA_CTRL_PDN]) begin
                        upd = 1'b1;
                    end
                    s_nxt.swrst = wv[`ANA_CTRL_SWRST];
                    // Reset and restart self-clear, so they read back zero.
                    wv[`ANA_CTRL_SWRST]  = 1'b0;
                    wv[`ANA_CTRL_RESTRT] = 1'b0;
                    s_nxt.ctrl = wv;
                end
                `ANA_IDX_ADV: begin
                    wv = merge({9'h000, s_r.pend, s_r.sel}, wb_dat_i,
                               wb_sel_i);
                    // Held pending; the applied copy is not touched here.
                    s_nxt.pend = wv[`ANA_ADV_10M_HI:`ANA_ADV_10M_LO];
                    s_nxt.sel  = wv[`ANA_SEL_HI:0];
                end
                `ANA_IDX_GIG: begin
                    wv = merge({6'h00, s_r.gig, 8'h00}, wb_dat_i, wb_sel_i);
                    s_nxt.gig = wv[`ANA_GIG_FD:`ANA_GIG_HD];
                end
                `ANA_IDX_PSC: begin
                    wv = merge({13'h0000, s_r.pdn2, 2'h0}, wb_dat_i,
                               wb_sel_i);
                    if (s_r.pdn2 && !wv[`ANA_PSC_PDN]) begin
                        upd = 1'b1;
                    end
                    s_nxt.pdn2 = wv[`ANA_PSC_PDN];
                end
                default: begin
                    wv = 16'h0000;
                end
            endcase
        end
        // Apply pending advertisement; the selector is not part of it.
        if (upd) begin
            s_nxt.app   = s_nxt.pend;
            s_nxt.rstrt = 1'b1;
        end
        // Forced 1000 keeps negotiation alive with one gigabit mode.
        s_nxt.run = s_r.ctrl[`ANA_CTRL_ANEN] || forced;
        if (forced) begin
            s_nxt.adv = {11'h000, s_r.sel};
            s_nxt.fd  = s_r.ctrl[`ANA_CTRL_DUPLEX];
            s_nxt.hd  = !s_r.ctrl[`ANA_CTRL_DUPLEX];
        end else begin
            s_nxt.adv = {9'h000, s_r.app, s_r.sel};
            s_nxt.fd  = s_r.gig[1];
            s_nxt.hd  = s_r.gig[0];
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Hardware reset only; software reset leaves the selector alone.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.st     <= ana_pkg::ANA_IDLE;
            s_r.ack    <= 1'b0;
            s_r.dat    <= 32'h0000_0000;
            s_r.ctrl   <= `ANA_CTRL_RST;
            s_r.pdn2   <= 1'b0;
            s_r.gig    <= `ANA_GIG_RST;
            s_r.pend   <= `ANA_ADV10_RST;
            s_r.app    <= `ANA_ADV10_RST;
            s_r.sel    <= `ANA_SEL_RST;
            s_r.lnk_s1 <= 1'b0;
            s_r.lnk_s2 <= 1'b0;
            s_r.lnk_d  <= 1'b0;
            s_r.adv    <= 16'h0000;
            s_r.fd     <= 1'b0;
            s_r.hd     <= 1'b0;
            s_r.run    <= 1'b0;
            s_r.rstrt  <= 1'b0;
            s_r.swrst  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o      = s_r.dat;
    assign wb_ack_o      = s_r.ack;
    assign adv_word_o    = s_r.adv;
    assign adv_1000_fd_o = s_r.fd;
    assign adv_1000_hd_o = s_r.hd;
    assign an_run_o      = s_r.run;
    assign an_restart_o  = s_r.rstrt;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_hold;
        !upd |=> s_r.app == $past(s_r.app);
    endproperty
    a_hold: assert property (p_hold)
        else $error("advertisement applied without an update event");

    // The restart pulse is registered at the same edge as the applied copy.
    property p_apply;
        upd |=> s_r.app == s_r.pend && an_restart_o;
    endproperty
    a_apply: assert property (p_apply)
        else $error("pending advertisement not applied");

    property p_force;
        forced && $stable(s_r.ctrl) |=> an_run_o &&
            adv_1000_fd_o == $past(s_r.ctrl[`ANA_CTRL_DUPLEX]) &&
            adv_1000_hd_o != adv_1000_fd_o;
    endproperty
    a_force: assert property (p_force)
        else $error("forced 1000 advertisement wrong");

    property p_ign;
        forced |=> adv_word_o[8:5] == 4'h0;
    endproperty
    a_ign: assert property (p_ign)
        else $error("10/100 bits advertised in forced 1000");

    property p_sel;
        s_r.swrst |-> $stable(s_r.sel);
    endproperty
    a_sel: assert property (p_sel)
        else $error("selector changed by software reset");

    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack held longer than one cycle");

endmodule

// >>> dv/ana_lp_model.sv
`timescale 1ns/1ps

// ************************************************************
// Remote copper link partner: base pages and link level.
// ************************************************************
module ana_lp_model (
    input  wire logic        clk,
    output logic      [15:0] rx_page_o,
    output logic             rx_page_valid_o,
    output logic             link_up_o
);
    // Idle line carries no page and the link starts up.
    initial begin
        rx_page_o       = 16'h0000;
        rx_page_valid_o = 1'b0;
        link_up_o       = 1'b1;
    end

    // One whole word per valid pulse; the line then shows the inverse so
    // that a design sampling outside the pulse picks up wrong bits.
    task automatic send_page(input logic [15:0] w);
        @(posedge clk);
        rx_page_o       <= w;
        rx_page_valid_o <= 1'b1;
        @(posedge clk);
        rx_page_valid_o <= 1'b0;
        rx_page_o       <= ~w;
    endtask

    // Copper link level, changed just after an edge.
    task automatic set_link(input logic v);
        @(posedge clk);
        link_up_o <= v;
    endtask
endmodule

// >>> dv/ana_regs_tb_top.sv
`timescale 1ns/1ps

// ************************************************************
// Register bank bench over classic Wishbone.
// ************************************************************
module ana_regs_tb_top;
    logic        clk, rst, cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rd_q, wb_dat_o;
    logic        wb_ack_o, link, pvld, fd, hd, run, rstrt;
    logic [15:0] page, adv;
    int          n_mismatch, num_checks, n_rst, i;

    ana_regs i_ana_regs (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .link_up_pin(link), .rx_page_i(page), .rx_page_valid_i(pvld),
        .adv_word_o(adv), .adv_1000_fd_o(fd), .adv_1000_hd_o(hd),
        .an_run_o(run), .an_restart_o(rstrt));

    ana_lp_model i_ana_lp_model (.clk(clk), .rx_page_o(page),
        .rx_page_valid_o(pvld), .link_up_o(link));

    // Clock of 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Count restart pulses; a pulse stands one cycle, so every edge counts.
    always @(posedge clk) begin
        if (rst === 1'b1) n_rst <= 0;
        else if (rstrt === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One classic cycle; ack, read data and release all belong to the
    // rising edge at which ack is sampled high, so nothing races the slave.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h3;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd_q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // Let derived outputs land, then look between edges.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        {rst, cyc, stb, we, adr, sel, wdat} = {1'b1, 47'h0};
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle(2);
        chk(adv, 16'h0061);
        chk({run, fd, hd}, 3'h7);
        wb(0, 8'h10, 0);
        chk(rd_q, 32'h61);
        wb(0, 8'h14, 0);
        chk(rd_q, 32'h0);
        $display("test reset done");
        // Pending advert is not applied until the restart.
        wb(1, 8'h10, 16'h0001);
        wb(0, 8'h10, 0);
        chk(rd_q, 32'h1);
        settle(4);
        chk(adv, 16'h0061);
        wb(1, 8'h00, 16'h1300);
        settle(4);
        chk(adv, 16'h0001);
        chk(n_rst, 1);
        // Software reset applies advert and keeps the selector.
        wb(1, 8'h10, 16'h0042);
        settle(4);
        chk(adv, 16'h0002);
        wb(1, 8'h00, 16'h9100);
        settle(4);
        chk(adv, 16'h0042);
        wb(0, 8'h10, 0);
        chk(rd_q, 32'h42);
        $display("test pending done");
        // Power-down exits and link loss.
        wb(1, 8'h10, 16'h0022);
        wb(1, 8'h00, 16'h1900);
        settle(4);
        chk(adv, 16'h0042);
        wb(1, 8'h00, 16'h1100);
        settle(4);
        chk(adv, 16'h0022);
        wb(1, 8'h10, 16'h0062);
        wb(1, 8'h40, 16'h0004);
        wb(1, 8'h40, 16'h0000);
        settle(4);
        chk(adv, 16'h0062);
        wb(1, 8'h10, 16'h0002);
        i_ana_lp_model.set_link(1'b0);
        settle(8);
        chk(adv, 16'h0002);
        chk(n_rst, 5);
        i_ana_lp_model.set_link(1'b1);
        $display("test update done");
        // Forced 1000 keeps negotiation and ignores advert bits.
        wb(1, 8'h10, 16'h0062);
        wb(1, 8'h00, 16'h0340);
        settle(4);
        chk({run, fd, hd}, 3'h6);
        chk(adv, 16'h0002);
        wb(1, 8'h24, 16'h0000);
        settle(4);
        chk({run, fd, hd}, 3'h6);
        wb(1, 8'h00, 16'h0040);
        settle(4);
        chk({run, fd, hd}, 3'h5);
        wb(1, 8'h00, 16'h0000);
        settle(4);
        chk(run, 1'b0);
        wb(1, 8'h00, 16'h1100);
        settle(4);
        chk({run, fd, hd}, 3'h4);
        chk(adv, 16'h0062);
        $display("test forced done");
        // Each partner bit alone, read through the bus.
        for (i = 0; i < 16; i++) begin
            i_ana_lp_model.send_page(16'h0001 << i);
            settle(1);
            wb(0, 8'h14, 0);
            chk(rd_q, 32'h1 << i);
        end
        wb(1, 8'h14, 16'h1234);
        wb(0, 8'h14, 0);
        chk(rd_q, 32'h8000);
        wb(1, 8'h00, 16'h9100);
        settle(2);
        wb(0, 8'h14, 0);
        chk(rd_q, 32'h0);
        wb(0, 8'h44, 0);
        chk(rd_q, 32'hf);
        wb(0, 8'h24, 0);
        chk(rd_q, 32'h0);
        wb(1, 8'h3c, 16'hffff);
        wb(0, 8'h3c, 0);
        chk(rd_q, 32'h0);
        $display("test partner done");
        end_sim();
    end
endmodule
